// ==== shared/vmsp_pkg.sv ====
// vmsp_pkg: constants shared by both ends of the mixer stream ports
// assumes one core clock, synchronous active-low reset
package vmsp_pkg;
  // ----------------------------------------
  // build-time stream shape
  // ----------------------------------------
  localparam int PPC = 2;
  localparam int BPC = 10;
  localparam int NCOMP = 4;
  localparam int NLAYERS = 2;
  localparam int DATA_W = ((NCOMP * BPC * PPC + 7) / 8) * 8;
  localparam int PIX_W = NCOMP * BPC;
  // ----------------------------------------
  // internal buffering and flush
  // ----------------------------------------
  localparam int BUF_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam logic [3:0] FLUSH_CYCLES = 4'h6;
  // ----------------------------------------
  // colour formats
  // ----------------------------------------
  typedef enum logic [2:0] {
    VMSP_RGB = 3'h0,
    VMSP_YUV444 = 3'h1,
    VMSP_YUV422 = 3'h2,
    VMSP_RGBA = 3'h3,
    VMSP_YUVA = 3'h4
  } vmsp_fmt_t;
  // component slot positions inside a pixel, and where pixel 1 starts in the word (3- and 4-component)
  localparam int SLOT0 = 0;
  localparam int SLOT1 = 10;
  localparam int SLOT2 = 20;
  localparam int SLOT3 = 30;
  localparam int PIX1_BASE3 = 30;
  localparam int PIX1_BASE4 = 40;
endpackage

// ==== shared/vmsp_stream_if.sv ====
// vmsp_stream_if: video streams between source, mixer end and sink
// assumes the bench drives CLOCK and RST_B
`timescale 1ns/1ps
interface vmsp_stream_if (
  input wire logic CLOCK,
  input wire logic RST_B
);
  logic [vmsp_pkg::NLAYERS-1:0] in_valid;
  logic [vmsp_pkg::NLAYERS-1:0] in_ready;
  logic [vmsp_pkg::NLAYERS*vmsp_pkg::DATA_W-1:0] in_data;
  logic [vmsp_pkg::NLAYERS-1:0] in_user;
  logic [vmsp_pkg::NLAYERS-1:0] in_last;
  logic out_valid;
  logic out_ready;
  logic [vmsp_pkg::DATA_W-1:0] out_data;
  logic out_user;
  logic out_last;
  logic irq;
  modport device (
    input CLOCK, RST_B, in_valid, in_data, in_user, in_last, out_ready,
    output in_ready, out_valid, out_data, out_user, out_last, irq
  );
  modport partner (
    input CLOCK, RST_B, in_ready, out_valid, out_data, out_user, out_last, irq,
    output in_valid, in_data, in_user, in_last, out_ready
  );
endinterface

// ==== logic/vmsp_pack.sv ====
// vmsp_pack: packs component values into a stream word by format
// assumes components are BPC wide, pixel 0 in c0..c3
`timescale 1ns/1ps
module vmsp_pack (
  // format
  input wire vmsp_pkg::vmsp_fmt_t fmt,
  // pixel 0 and 1 components (g/y, b/u, r/v, alpha)
  input wire logic [vmsp_pkg::PIX_W-1:0] pix0,
  input wire logic [vmsp_pkg::PIX_W-1:0] pix1,
  // packed word
  output logic [vmsp_pkg::DATA_W-1:0] word
);
  localparam int B = vmsp_pkg::BPC;
  wire [B-1:0] c00 = pix0[vmsp_pkg::SLOT0 +: B];
  wire [B-1:0] c01 = pix0[vmsp_pkg::SLOT1 +: B];
  wire [B-1:0] c02 = pix0[vmsp_pkg::SLOT2 +: B];
  wire [B-1:0] c10 = pix1[vmsp_pkg::SLOT0 +: B];
  wire [3*B-1:0] p0_3 = pix0[3*B-1:0];
  wire [3*B-1:0] p1_3 = pix1[3*B-1:0];
  wire [vmsp_pkg::DATA_W-1:0] w3 = {{(vmsp_pkg::DATA_W-6*B){1'b0}}, p1_3, p0_3};
  wire [vmsp_pkg::DATA_W-1:0] w422 = {{(vmsp_pkg::DATA_W-4*B){1'b0}}, c02, c10, c01, c00};
  wire [vmsp_pkg::DATA_W-1:0] w4 = {pix1, pix0};
  always_comb
  begin
    case (fmt)
      vmsp_pkg::VMSP_RGB, vmsp_pkg::VMSP_YUV444: word = w3;
      vmsp_pkg::VMSP_YUV422: word = w422;
      vmsp_pkg::VMSP_RGBA, vmsp_pkg::VMSP_YUVA: word = w4;
      default: word = w3;
    endcase
  end
endmodule

// ==== logic/vmsp_device.sv ====
// vmsp_device: stream end of the mixer with throttling and line flush
// assumes partner obeys valid/ready hold and tuser/tlast framing
`timescale 1ns/1ps
module vmsp_device (
  // stream ports
  vmsp_stream_if.device vs
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    VMSP_RUN = 2'h1,
    VMSP_FLUSH = 2'h2
  } vmsp_state_t;
  localparam int W = vmsp_pkg::DATA_W;
  vmsp_state_t state_r;
  vmsp_state_t state_nxt;
  logic [3:0] flush_cnt_r;
  logic [W-1:0] buf_data_r [vmsp_pkg::BUF_DEPTH];
  logic buf_user_r [vmsp_pkg::BUF_DEPTH];
  logic buf_last_r [vmsp_pkg::BUF_DEPTH];
  logic [vmsp_pkg::PTR_W-1:0] wr_ptr_r;
  logic [vmsp_pkg::PTR_W-1:0] rd_ptr_r;
  logic [vmsp_pkg::PTR_W:0] count_r;
  logic in_ready_r;
  logic out_valid_r;
  logic out_user_r;
  logic out_last_r;
  logic irq_r;
  logic frame_done_r;
  logic [W-1:0] out_data_r;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  // only the primary input (index 0) feeds the output path; extra layers are held off
  wire in_fire = vs.in_valid[0] && in_ready_r;
  wire out_fire = out_valid_r && vs.out_ready;
  wire out_slot_free = !out_valid_r || vs.out_ready;
  wire buf_has = count_r != '0;
  wire pop = out_slot_free && buf_has;
  wire push = in_fire;
  wire [vmsp_pkg::PTR_W:0] count_nxt = count_r + {{vmsp_pkg::PTR_W{1'b0}}, push}
    - {{vmsp_pkg::PTR_W{1'b0}}, pop};
  wire line_end = in_fire && vs.in_last[0];
  wire buf_room = count_nxt < (vmsp_pkg::PTR_W+1)'(vmsp_pkg::BUF_DEPTH - 1);
  wire flush_done = flush_cnt_r == 4'h1;
  // ----------------------------------------
  // flush state machine
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      VMSP_RUN: if (line_end) state_nxt = VMSP_FLUSH;
      VMSP_FLUSH: if (flush_done) state_nxt = VMSP_RUN;
      default: state_nxt = VMSP_RUN;
    endcase
  end
  wire ready_nxt = (state_nxt == VMSP_RUN) && buf_room;
  // ----------------------------------------
  // next register values
  // ----------------------------------------
  wire [3:0] flush_cnt_nxt = line_end ? vmsp_pkg::FLUSH_CYCLES :
    (flush_cnt_r != 4'h0 ? flush_cnt_r - 4'h1 : 4'h0);
  wire [vmsp_pkg::PTR_W-1:0] wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
  wire [vmsp_pkg::PTR_W-1:0] rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  wire frame_done_nxt = (out_fire && out_user_r) ? 1'b0 :
    frame_done_r | (out_fire && out_last_r);
  wire irq_nxt = out_fire && out_last_r && !frame_done_r && out_user_r;
  // ----------------------------------------
  // output stage next values
  // ----------------------------------------
  wire out_valid_nxt = out_slot_free ? buf_has : out_valid_r;
  wire [W-1:0] out_data_nxt = out_slot_free ? buf_data_r[rd_ptr_r] : out_data_r;
  wire out_user_nxt = out_slot_free ? buf_user_r[rd_ptr_r] : out_user_r;
  wire out_last_nxt = out_slot_free ? buf_last_r[rd_ptr_r] : out_last_r;
  // ----------------------------------------
  // flush control registers
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      state_r <= VMSP_RUN;
      flush_cnt_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      flush_cnt_r <= flush_cnt_nxt;
    end
  end
  // ----------------------------------------
  // buffer pointers and fill count
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end
  // ----------------------------------------
  // input ready
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
      in_ready_r <= 1'b0;
    else
      in_ready_r <= ready_nxt;
  end
  // ----------------------------------------
  // frame tracking and interrupt
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      frame_done_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      frame_done_r <= frame_done_nxt;
      irq_r <= irq_nxt;
    end
  end
  // ----------------------------------------
  // buffer storage
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (push)
    begin
      buf_data_r[wr_ptr_r] <= vs.in_data[W-1:0];
      buf_user_r[wr_ptr_r] <= vs.in_user[0];
      buf_last_r[wr_ptr_r] <= vs.in_last[0];
    end
  end
  // ----------------------------------------
  // output stage registers
  // ----------------------------------------
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      out_user_r <= 1'b0;
      out_last_r <= 1'b0;
    end
    else
    begin
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
      out_user_r <= out_user_nxt;
      out_last_r <= out_last_nxt;
    end
  end
  // ----------------------------------------
  // extra layers: never accepted
  // ----------------------------------------
  wire [vmsp_pkg::NLAYERS-1:0] layer_ready;
  assign layer_ready[0] = in_ready_r;
  for (genvar gi = 1; gi < vmsp_pkg::NLAYERS; gi++)
  begin : g_extra_layer
    assign layer_ready[gi] = 1'b0;
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign vs.in_ready = layer_ready;
  assign vs.out_valid = out_valid_r;
  assign vs.out_data = out_data_r;
  assign vs.out_user = out_user_r;
  assign vs.out_last = out_last_r;
  assign vs.irq = irq_r;
endmodule

// ==== logic/vmsp_partner.sv ====
// vmsp_partner: source of the primary stream and sink of the output
// assumes user side offers pixels with a valid/ready handshake
`timescale 1ns/1ps
module vmsp_partner (
  // stream ports
  vmsp_stream_if.partner vs,
  // user source side
  input wire vmsp_pkg::vmsp_fmt_t FMT,
  input wire logic SRC_VALID,
  input wire logic [vmsp_pkg::PIX_W-1:0] SRC_PIX0,
  input wire logic [vmsp_pkg::PIX_W-1:0] SRC_PIX1,
  input wire logic SRC_SOF,
  input wire logic SRC_EOL,
  output logic SRC_READY,
  // user sink side
  input wire logic SNK_READY,
  output logic SNK_VALID,
  output logic [vmsp_pkg::DATA_W-1:0] SNK_DATA,
  output logic SNK_SOF,
  output logic SNK_EOL,
  output logic SNK_IRQ
);
  logic [vmsp_pkg::DATA_W-1:0] packed_word;
  logic tx_valid_r, tx_user_r, tx_last_r, snk_valid_r, snk_sof_r, snk_eol_r, irq_r;
  logic [vmsp_pkg::DATA_W-1:0] tx_data_r, snk_data_r;
  vmsp_pack u_pack (
    .fmt(FMT),
    .pix0(SRC_PIX0),
    .pix1(SRC_PIX1),
    .word(packed_word)
  );
  // ----------------------------------------
  // source: hold beat until taken
  // ----------------------------------------
  wire tx_free = !tx_valid_r || vs.in_ready[0];
  assign SRC_READY = tx_free;
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      tx_valid_r <= 1'b0;
      tx_data_r <= '0;
      tx_user_r <= 1'b0;
      tx_last_r <= 1'b0;
    end
    else if (tx_free)
    begin
      tx_valid_r <= SRC_VALID;
      tx_data_r <= packed_word;
      tx_user_r <= SRC_SOF;
      tx_last_r <= SRC_EOL;
    end
  end
  // ----------------------------------------
  // sink: register output beats
  // ----------------------------------------
  wire snk_free = !snk_valid_r || SNK_READY;
  always_ff @(posedge vs.CLOCK)
  begin
    if (!vs.RST_B)
    begin
      snk_valid_r <= 1'b0;
      snk_data_r <= '0;
      snk_sof_r <= 1'b0;
      snk_eol_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= vs.irq;
      if (snk_free)
      begin
        snk_valid_r <= vs.out_valid;
        snk_data_r <= vs.out_data;
        snk_sof_r <= vs.out_user;
        snk_eol_r <= vs.out_last;
      end
    end
  end
  assign vs.in_valid = {{(vmsp_pkg::NLAYERS-1){1'b0}}, tx_valid_r};
  assign vs.in_data = {{((vmsp_pkg::NLAYERS-1)*vmsp_pkg::DATA_W){1'b0}}, tx_data_r};
  assign vs.in_user = {{(vmsp_pkg::NLAYERS-1){1'b0}}, tx_user_r};
  assign vs.in_last = {{(vmsp_pkg::NLAYERS-1){1'b0}}, tx_last_r};
  assign vs.out_ready = snk_free;
  assign SNK_VALID = snk_valid_r;
  assign SNK_DATA = snk_data_r;
  assign SNK_SOF = snk_sof_r;
  assign SNK_EOL = snk_eol_r;
  assign SNK_IRQ = irq_r;
endmodule

// ==== verif/vmsp_stream_chk.sv ====
// vmsp_stream_chk: assertions on the stream between the two ends
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module vmsp_stream_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // input streams
  input wire logic [vmsp_pkg::NLAYERS-1:0] in_valid,
  input wire logic [vmsp_pkg::NLAYERS-1:0] in_ready,
  input wire logic [vmsp_pkg::NLAYERS-1:0] in_last,
  // output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [vmsp_pkg::DATA_W-1:0] out_data,
  input wire logic out_user,
  input wire logic out_last,
  input wire logic irq
);
  // ----------------------------------------
  // beats in flight
  // ----------------------------------------
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire in_take = in_valid[0] & in_ready[0];
  wire out_take = out_valid & out_ready;
  assign cnt_nxt = cnt_r + {3'h0, in_take} - {3'h0, out_take};
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_nxt;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  sequence s_last_taken;
    in_take && in_last[0];
  endsequence
  sequence s_flush;
    !in_ready[0] [*6];
  endsequence
  a_flush_gap: assert property (s_last_taken |=> s_flush)
    else $error("input ready rose during flush");
  a_reset_clears: assert property (disable iff (1'b0)
    !RST_B |=> !out_valid && !irq && in_ready == '0) else $error("reset left outputs set");
  a_extra_idle: assert property (!in_ready[1]) else $error("extra layer ready");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_user) && $stable(out_last)) else $error("output beat changed");
  a_out_latency: assert property (in_take && !out_valid |-> ##[1:2] out_valid)
    else $error("beat late at output");
  a_no_ghost: assert property (out_valid |-> cnt_r != 4'h0)
    else $error("output without buffered beat");
  a_fill_limit: assert property (cnt_r <= vmsp_pkg::BUF_DEPTH + 1)
    else $error("input taken beyond buffer");
  a_irq_pulse: assert property (irq |=> !irq) else $error("irq longer than a cycle");
  a_irq_cause: assert property (irq |-> $past(out_take && out_user && out_last))
    else $error("irq without frame end");
endmodule

// ==== verif/test_video_mixer_stream_ports.sv ====
// test_video_mixer_stream_ports: both ends joined, user sides driven
// assumes the design files and package are compiled first
`timescale 1ns/1ps
module test_video_mixer_stream_ports;
  // ----------------------------------------
  // stimulus and scoreboard
  // ----------------------------------------
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  vmsp_pkg::vmsp_fmt_t fmt = vmsp_pkg::VMSP_RGB;
  logic src_valid = 1'b0;
  logic [vmsp_pkg::PIX_W-1:0] pix0 = '0;
  logic [vmsp_pkg::PIX_W-1:0] pix1 = '0;
  logic sof = 1'b0;
  logic eol = 1'b0;
  logic snk_ready = 1'b0;
  logic stall = 1'b0;
  logic src_ready, snk_valid, snk_sof, snk_eol, snk_irq;
  logic [vmsp_pkg::DATA_W-1:0] snk_data;
  logic [vmsp_pkg::DATA_W+1:0] exp_q[$];
  logic [31:0] seed = 32'hEF3E27C6;
  int n_fail = 0;
  int total_checks = 0;
  int n_irq = 0;
  int n_take = 0;
  int f;
  int k;
  vmsp_stream_if vs (.CLOCK(CLOCK), .RST_B(RST_B));
  vmsp_device u_vmsp_device (.vs(vs.device));
  vmsp_partner u_vmsp_partner (.vs(vs.partner), .FMT(fmt), .SRC_VALID(src_valid),
    .SRC_PIX0(pix0), .SRC_PIX1(pix1), .SRC_SOF(sof), .SRC_EOL(eol), .SRC_READY(src_ready),
    .SNK_READY(snk_ready), .SNK_VALID(snk_valid), .SNK_DATA(snk_data), .SNK_SOF(snk_sof),
    .SNK_EOL(snk_eol), .SNK_IRQ(snk_irq));
  vmsp_stream_chk u_vmsp_stream_chk (.CLOCK(CLOCK), .RST_B(RST_B), .in_valid(vs.in_valid),
    .in_ready(vs.in_ready), .in_last(vs.in_last), .out_valid(vs.out_valid),
    .out_ready(vs.out_ready), .out_data(vs.out_data), .out_user(vs.out_user),
    .out_last(vs.out_last), .irq(vs.irq));
  initial
  begin
    forever #25 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [vmsp_pkg::DATA_W-1:0] pack(vmsp_pkg::vmsp_fmt_t m,
      logic [39:0] a, logic [39:0] b);
    if (m == vmsp_pkg::VMSP_YUV422)
      return {40'h0, a[29:20], b[9:0], a[19:10], a[9:0]};
    if (m == vmsp_pkg::VMSP_RGBA || m == vmsp_pkg::VMSP_YUVA)
      return {b, a};
    return {20'h0, b[29:0], a[29:0]};
  endfunction
  task automatic check(input logic [vmsp_pkg::DATA_W+1:0] e, input logic [vmsp_pkg::DATA_W+1:0] g);
    total_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic s, input logic e);
    logic [63:0] a;
    logic [63:0] b;
    int i;
    a = {rnd(), rnd()};
    b = {rnd(), rnd()};
    if (fmt == vmsp_pkg::VMSP_YUV422)
      b[29:20] = a[29:20];
    src_valid <= 1'b1;
    pix0 <= a[39:0];
    pix1 <= b[39:0];
    sof <= s;
    eol <= e;
    i = 0;
    @(negedge CLOCK);
    while (src_ready !== 1'b1 && i < 200)
    begin
      @(negedge CLOCK);
      i++;
    end
    if (i == 200)
    begin
      n_fail++;
      wrap_up();
    end
    @(posedge CLOCK);
    exp_q.push_back({s, e, pack(fmt, a[39:0], b[39:0])});
    n_take++;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 500 && exp_q.size() != 0; i++)
      @(posedge CLOCK);
    if (exp_q.size() != 0)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  always @(posedge CLOCK)
    snk_ready <= !stall && ((rnd() & 32'h3) != 32'h0);
  always @(negedge CLOCK)
  begin
    if (RST_B && snk_valid && snk_ready)
    begin
      if (exp_q.size() == 0)
        check('1, {snk_sof, snk_eol, snk_data});
      else
        check(exp_q.pop_front(), {snk_sof, snk_eol, snk_data});
    end
    if (RST_B && snk_irq)
      n_irq++;
  end
  initial
  begin
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    for (f = 0; f < 5; f++)
    begin
      fmt <= vmsp_pkg::vmsp_fmt_t'(f);
      @(posedge CLOCK);
      for (k = 0; k < (f == 0 ? 1 : 6); k++)
      begin
        send(k == 0, k == (f == 0 ? 0 : 5));
        if ((rnd() & 32'h1) != 32'h0)
        begin
          src_valid <= 1'b0;
          @(posedge CLOCK);
        end
      end
      src_valid <= 1'b0;
      drain();
    end
    // sink stalls while the source keeps offering
    stall <= 1'b1;
    repeat (3) @(posedge CLOCK);
    n_take = 0;
    fork
      for (k = 0; k < 8; k++)
        send(k == 0, k == 7);
      begin
        repeat (40) @(posedge CLOCK);
        check(82'(vmsp_pkg::BUF_DEPTH + 2), 82'(n_take));
        stall <= 1'b0;
      end
    join
    src_valid <= 1'b0;
    drain();
    check(82'h1, 82'(n_irq));
    // reset in mid-line, then a fresh line
    send(1'b1, 1'b0);
    src_valid <= 1'b0;
    RST_B <= 1'b0;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    exp_q.delete();
    check(82'h10, {77'h0, src_ready, vs.in_ready[0], vs.out_valid, snk_valid, snk_irq});
    @(posedge CLOCK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLOCK);
    send(1'b1, 1'b0);
    send(1'b0, 1'b1);
    src_valid <= 1'b0;
    drain();
    wrap_up();
  end
endmodule
